// ==== verilog/acc_params.svh ====
// Purpose: constants for the converter configuration and control block
// Assumes: 40 MHz clock, APB byte addresses four times the register index
// Notes:   definitions only
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH
`define ACC_IDX_FILT        12'h007
`define ACC_IDX_DLY         12'h008
`define ACC_IDX_MGL         12'h01b
`define ACC_IDX_MGH         12'h01c
`define ACC_IDX_AGL         12'h01d
`define ACC_IDX_AGH         12'h01e
`define ACC_IDX_CGL         12'h01f
`define ACC_IDX_CGH         12'h020
`define ACC_IDX_RUN         12'h30d
`define ACC_IDX_STAT        12'h310
`define ACC_RST8            8'h00
`define ACC_CLK_KHZ         40000
`define ACC_STEP_NS         5000
`define ACC_STEP_CYC        ((`ACC_STEP_NS * (`ACC_CLK_KHZ / 1000)) / 1000)
`define ACC_DLY_MAX_STEPS   6'h28
`define ACC_SETTLE0_US      4300
`define ACC_SETTLE1_US      2300
`define ACC_SETTLE2_US      1300
`define ACC_US_CYC          (`ACC_CLK_KHZ / 1000)
`define ACC_SINGLE_RUNS     4'h8
`define ACC_CT0_US          768
`define ACC_CT1_US          1536
`define ACC_CT2_US          3072
`define ACC_CT3_US          12288
`endif

// ==== verilog/acc_pkg.sv ====
// Purpose: shared types of the converter control block
// Assumes: nothing beyond the constants header
// Notes:   run modes follow the two-bit run field
package acc_pkg;
  typedef enum logic [1:0] {
    ACC_MODE_OFF    = 2'h0,
    ACC_MODE_SINGLE = 2'h1,
    ACC_MODE_CONT   = 2'h2,
    ACC_MODE_RSVD   = 2'h3
  } acc_mode_t;
  typedef enum logic [1:0] {ACC_IDLE, ACC_DELAY, ACC_RUN} acc_state_t;
endpackage : acc_pkg

// ==== verilog/acc_timer.sv ====
// Purpose: down counter that paces delay and settle timing
// Assumes: load and tick come from the same clock domain
// Notes:   done pulses one cycle when the count reaches zero
`timescale 1ns/1ps
module acc_timer
  import acc_pkg::*;
#(
  parameter int W = 20
)(
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  input  wire logic         tick,
  output logic              busy,
  output logic              done
);
  logic [W-1:0] cnt_reg;
  // count down on each tick after a load
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      cnt_reg <= '0;
    else if (load)
      cnt_reg <= value;
    else if (tick && cnt_reg != '0)
      cnt_reg <= cnt_reg - 1'b1;
  end
  assign busy = (cnt_reg != '0);
  assign done = tick && (cnt_reg == {{(W-1){1'b0}}, 1'b1}) && !load;
endmodule : acc_timer

// ==== verilog/acc_ctrl.sv ====
// Purpose: configuration, trim and start control of three converters
// Assumes: APB slave, 40 MHz CLK, synchronous active-low RESET_N
// Notes:   trims load from one-time memory at reset release
// How it works
// - settle code 00/01/10 waits 4.3/2.3/1.3 ms; 11 reserved
// - voltage filter field selects cut-off code, 7 aliases 240 Hz
// - current group filter field uses the same cut-off coding
// - main converter enable held off by delay field times 5 us
// - delay codes above forty steps mean no delay
// - main gain trim is nine bits, low byte plus top bit
// - main offset trim is seven bits
// - aux gain trim is nine bits, low byte plus top bit
// - aux offset trim is seven bits
// - trims copied from one-time memory at device reset
// - stored trims drive correction outputs without software action
// - current gain trim is eleven bits, low byte plus three bits
// - current offset trim is five bits
// - main settings latch only on start; start reads as zero
// - mode 01 runs eight rounds then stops; 00 off, 11 reserved
// - mode 10 runs continuously until stopped
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "acc_params.svh"
module acc_ctrl
  import acc_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [13:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [63:0] OTP_TRIM,
  input  wire logic        ROUND_DONE,
  output logic             MAIN_CONV_EN,
  output logic             AUX_SETTLED,
  output logic [2:0]       VOLT_CUTOFF,
  output logic             VOLT_FILT_EN,
  output logic [2:0]       CURR_CUTOFF,
  output logic             CURR_FILT_EN,
  output logic [1:0]       CURR_CONV_TIME,
  output logic [15:0]      CURR_TIME_US,
  output logic signed [8:0]  MAIN_GAIN,
  output logic signed [6:0]  MAIN_OFFSET,
  output logic signed [8:0]  AUX_GAIN,
  output logic signed [6:0]  AUX_OFFSET,
  output logic signed [10:0] CURR_GAIN,
  output logic signed [4:0]  CURR_OFFSET
);
  logic [7:0] filt_reg, dly_reg, mgl_reg, mgh_reg, agl_reg, agh_reg;
  logic [7:0] cgl_reg, cgh_reg, run_reg;
  acc_mode_t  mode_act_reg;
  logic [3:0] rounds_reg;
  logic       otp_done_reg;
  acc_state_t state_reg;
  logic       wr_en, rd_en, start, addr_ok;
  logic [11:0] idx;
  logic [5:0] dly_eff;
  logic       step_tick, dly_done, settle_busy;
  logic [7:0] step_cnt_reg;
  logic [17:0] settle_val;

  // register index from the byte address
  function automatic logic [11:0] idx_of(input logic [13:0] a);
    return a[13:2];
  endfunction : idx_of

  assign idx     = idx_of(PADDR);
  assign wr_en   = PSEL && PENABLE && PWRITE;
  assign rd_en   = PSEL && PENABLE && !PWRITE;
  assign PREADY  = 1'b1;
  assign addr_ok = (PADDR[1:0] == 2'h0) &&
                   (idx == `ACC_IDX_FILT || idx == `ACC_IDX_DLY ||
                    (idx >= `ACC_IDX_MGL && idx <= `ACC_IDX_CGH) ||
                    idx == `ACC_IDX_RUN || idx == `ACC_IDX_STAT);
  assign PSLVERR = PSEL && PENABLE && !addr_ok;
  assign start   = wr_en && (idx == `ACC_IDX_RUN) && PWDATA[2];

  // one-time trim load right after reset release
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
      otp_done_reg <= 1'b0;
    else
      otp_done_reg <= 1'b1;
  end

  // configuration registers written by software
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      filt_reg <= `ACC_RST8;
      dly_reg  <= `ACC_RST8;
      run_reg  <= `ACC_RST8;
    end
    else if (wr_en && addr_ok)
    begin
      if (idx == `ACC_IDX_FILT) filt_reg <= PWDATA[7:0];
      if (idx == `ACC_IDX_DLY)  dly_reg  <= PWDATA[7:0];
      if (idx == `ACC_IDX_RUN)  run_reg  <= {1'b0, PWDATA[6:3], 1'b0,
                                             PWDATA[1:0]};
    end
  end

  // trim registers: otp copy at reset, then software writable
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      {mgl_reg, mgh_reg, agl_reg, agh_reg} <= {4{`ACC_RST8}};
      {cgl_reg, cgh_reg} <= {2{`ACC_RST8}};
    end
    else if (!otp_done_reg)
    begin
      {mgl_reg, mgh_reg, agl_reg, agh_reg} <= OTP_TRIM[63:32];
      {cgl_reg, cgh_reg} <= OTP_TRIM[31:16];
    end
    else if (wr_en && addr_ok)
    begin
      if (idx == `ACC_IDX_MGL) mgl_reg <= PWDATA[7:0];
      if (idx == `ACC_IDX_MGH) mgh_reg <= PWDATA[7:0];
      if (idx == `ACC_IDX_AGL) agl_reg <= PWDATA[7:0];
      if (idx == `ACC_IDX_AGH) agh_reg <= PWDATA[7:0];
      if (idx == `ACC_IDX_CGL) cgl_reg <= PWDATA[7:0];
      if (idx == `ACC_IDX_CGH) cgh_reg <= PWDATA[7:0];
    end
  end

  // signed trim words for the correction path
  assign MAIN_GAIN   = $signed({mgh_reg[7], mgl_reg});
  assign MAIN_OFFSET = $signed(mgh_reg[6:0]);
  assign AUX_GAIN    = $signed({agh_reg[7], agl_reg});
  assign AUX_OFFSET  = $signed(agh_reg[6:0]);
  assign CURR_GAIN   = $signed({cgh_reg[7:5], cgl_reg});
  assign CURR_OFFSET = $signed(cgh_reg[4:0]);

  // read mux; start bit always returns zero
  always_comb
  begin
    PRDATA = 32'h0000_0000;
    if (rd_en && addr_ok)
    begin
      unique case (idx)
        `ACC_IDX_FILT: PRDATA[7:0] = filt_reg;
        `ACC_IDX_DLY:  PRDATA[7:0] = dly_reg;
        `ACC_IDX_MGL:  PRDATA[7:0] = mgl_reg;
        `ACC_IDX_MGH:  PRDATA[7:0] = mgh_reg;
        `ACC_IDX_AGL:  PRDATA[7:0] = agl_reg;
        `ACC_IDX_AGH:  PRDATA[7:0] = agh_reg;
        `ACC_IDX_CGL:  PRDATA[7:0] = cgl_reg;
        `ACC_IDX_CGH:  PRDATA[7:0] = cgh_reg;
        `ACC_IDX_RUN:  PRDATA[7:0] = run_reg;
        `ACC_IDX_STAT: PRDATA[7:0] = {4'h0, rounds_reg[2:0],
                                      MAIN_CONV_EN};
        default:       PRDATA = 32'h0000_0000;
      endcase
    end
  end

  // filter selection and enables per group
  assign VOLT_CUTOFF  = filt_reg[2:0];
  assign CURR_CUTOFF  = filt_reg[5:3];
  assign VOLT_FILT_EN = run_reg[3];
  assign CURR_FILT_EN = run_reg[4];
  assign CURR_CONV_TIME = run_reg[6:5];

  // conversion time in microseconds for the current converter
  always_comb
  begin
    unique case (run_reg[6:5])
      2'h0: CURR_TIME_US = 16'(`ACC_CT0_US);
      2'h1: CURR_TIME_US = 16'(`ACC_CT1_US);
      2'h2: CURR_TIME_US = 16'(`ACC_CT2_US);
      2'h3: CURR_TIME_US = 16'(`ACC_CT3_US);
    endcase
  end

  // undefined delay codes collapse to zero
  assign dly_eff = (dly_reg[5:0] > `ACC_DLY_MAX_STEPS) ? 6'h00
                                                        : dly_reg[5:0];

  // 5 us step enable
  always_ff @(posedge CLK)
  begin
    if (!RESET_N || step_tick)
      step_cnt_reg <= 8'h00;
    else
      step_cnt_reg <= step_cnt_reg + 8'h01;
  end
  assign step_tick = (step_cnt_reg == 8'(`ACC_STEP_CYC - 1));

  acc_timer #(.W(6)) u_dly (
    .clk     (CLK),
    .reset_n (RESET_N),
    .load    (start),
    .value   (dly_eff),
    .tick    (step_tick),
    .busy    (),
    .done    (dly_done)
  );

  // run control: settings latched only on start
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      state_reg    <= ACC_IDLE;
      mode_act_reg <= ACC_MODE_OFF;
      rounds_reg   <= 4'h0;
    end
    else if (start)
    begin
      mode_act_reg <= acc_mode_t'(PWDATA[1:0]);
      rounds_reg   <= 4'h0;
      state_reg    <= (PWDATA[1:0] == ACC_MODE_SINGLE ||
                       PWDATA[1:0] == ACC_MODE_CONT) ?
                      ((dly_eff == 6'h00) ? ACC_RUN : ACC_DELAY)
                      : ACC_IDLE;
    end
    else
    begin
      unique case (state_reg)
        ACC_IDLE:  state_reg <= ACC_IDLE;
        ACC_DELAY: if (dly_done) state_reg <= ACC_RUN;
        ACC_RUN:
        begin
          if (ROUND_DONE && mode_act_reg == ACC_MODE_SINGLE)
          begin
            rounds_reg <= rounds_reg + 4'h1;
            if (rounds_reg == `ACC_SINGLE_RUNS - 4'h1)
              state_reg <= ACC_IDLE;
          end
          // continuous mode runs until a new start with mode 00 or 11
        end
        default:   state_reg <= ACC_IDLE;
      endcase
    end
  end
  assign MAIN_CONV_EN = (state_reg == ACC_RUN);

  // aux settling wait restarts on every start write, not when the delay ends
  always_comb
  begin
    unique case (filt_reg[7:6])
      2'h0: settle_val = 18'(`ACC_SETTLE0_US * `ACC_US_CYC / 8);
      2'h1: settle_val = 18'(`ACC_SETTLE1_US * `ACC_US_CYC / 8);
      2'h2: settle_val = 18'(`ACC_SETTLE2_US * `ACC_US_CYC / 8);
      2'h3: settle_val = 18'h00000;
    endcase
  end

  logic [2:0] div8_reg;
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
      div8_reg <= 3'h0;
    else
      div8_reg <= div8_reg + 3'h1;
  end

  acc_timer #(.W(18)) u_settle (
    .clk     (CLK),
    .reset_n (RESET_N),
    .load    (start),
    .value   (settle_val),
    .tick    (div8_reg == 3'h7),
    .busy    (settle_busy),
    .done    ()
  );
  assign AUX_SETTLED = MAIN_CONV_EN && !settle_busy &&
                       filt_reg[7:6] != 2'h3;

  // main converter starts exactly when the delay ends
  a_delay_run: assert property (@(posedge CLK) disable iff (!RESET_N)
    state_reg == ACC_DELAY && dly_done |=> MAIN_CONV_EN)
    else $error("main converter not enabled after delay");
  // zero or undefined delay enables at once
  a_zero_delay: assert property (@(posedge CLK) disable iff (!RESET_N)
    start && PWDATA[1:0] == 2'h1 && dly_eff == 6'h00 |=> MAIN_CONV_EN)
    else $error("zero delay did not start at once");
  // start bit never reads back
  a_start_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
    rd_en && idx == `ACC_IDX_RUN |-> PRDATA[2] == 1'b0)
    else $error("start bit read as one");
  // mode only changes on a start
  a_mode_hold: assert property (@(posedge CLK) disable iff (!RESET_N)
    !start |=> $stable(mode_act_reg))
    else $error("run mode changed without start");
  // single run stops after eight rounds
  a_single_stop: assert property (@(posedge CLK) disable iff (!RESET_N)
    MAIN_CONV_EN && mode_act_reg == ACC_MODE_SINGLE && ROUND_DONE &&
    rounds_reg == 4'h7 && !start |=> !MAIN_CONV_EN)
    else $error("single run did not stop");
  // continuous run keeps going on round completion
  a_cont_run: assert property (@(posedge CLK) disable iff (!RESET_N)
    MAIN_CONV_EN && mode_act_reg == ACC_MODE_CONT && !start
    |=> MAIN_CONV_EN)
    else $error("continuous run stopped");
  // trims take the one-time copy after reset
  a_otp_load: assert property (@(posedge CLK) disable iff (!RESET_N)
    !otp_done_reg |=> {mgl_reg, mgh_reg} == $past(OTP_TRIM[63:48]))
    else $error("trim not loaded from one-time memory");
  // gain words take their top bits from the high trim byte
  a_gain_pair: assert property (@(posedge CLK) disable iff (!RESET_N)
    CURR_GAIN[10:8] == cgh_reg[7:5] && MAIN_GAIN[8] == mgh_reg[7])
    else $error("gain trim assembly wrong");
  // cut-off follows the field
  a_cutoff: assert property (@(posedge CLK) disable iff (!RESET_N)
    wr_en && addr_ok && idx == `ACC_IDX_FILT
    |=> VOLT_CUTOFF == $past(PWDATA[2:0]))
    else $error("voltage cut-off not updated");

  // a start that asks the main converter to run, or to halt
  sequence s_go;
    start && (PWDATA[1:0] == ACC_MODE_SINGLE ||
              PWDATA[1:0] == ACC_MODE_CONT);
  endsequence
  sequence s_halt;
    start && (PWDATA[1:0] == ACC_MODE_OFF ||
              PWDATA[1:0] == ACC_MODE_RSVD);
  endsequence
  // a delayed start keeps the converter off at first
  a_hold_off: assert property (@(posedge CLK) disable iff (!RESET_N)
    s_go ##0 dly_eff != 6'h00 |=> !MAIN_CONV_EN)
    else $error("main converter enabled before delay");
  // codes above forty steps start at once like zero
  a_undef_delay: assert property (@(posedge CLK) disable iff (!RESET_N)
    s_go ##0 dly_reg[5:0] > `ACC_DLY_MAX_STEPS |=> MAIN_CONV_EN)
    else $error("undefined delay code held off");
  // a start with mode 00 or 11 halts the converter
  a_halt: assert property (@(posedge CLK) disable iff (!RESET_N)
    s_halt |=> !MAIN_CONV_EN)
    else $error("converter kept running after halt");
  // reserved settle code never reports settled inputs
  a_settle_rsvd: assert property (@(posedge CLK) disable iff (!RESET_N)
    filt_reg[7:6] == 2'h3 |-> !AUX_SETTLED)
    else $error("settled flag with reserved settle code");
  // trims move only on the one-time copy or a bus write
  a_trim_hold: assert property (@(posedge CLK) disable iff (!RESET_N)
    otp_done_reg && !(wr_en && addr_ok) |=> $stable(MAIN_GAIN) &&
    $stable(CURR_GAIN))
    else $error("trim changed without a write");
endmodule : acc_ctrl

// ==== sim/test_adc_config_control.sv ====
// Purpose: self-checking bench for the converter control block
// Assumes: zero-wait APB, trims copied from OTP_TRIM after reset
// Notes:   random values come from a fixed-seed xorshift
`timescale 1ns/1ps
`include "acc_params.svh"
module test_adc_config_control
  import acc_pkg::*;
;
  logic               CLK, RESET_N, PSEL, PENABLE, PWRITE, ROUND_DONE;
  logic [13:0]        PADDR;
  logic [31:0]        PWDATA, PRDATA, rd, d;
  logic               PREADY, PSLVERR, MAIN_CONV_EN, AUX_SETTLED, err;
  logic               VOLT_FILT_EN, CURR_FILT_EN;
  logic [63:0]        OTP_TRIM;
  logic [2:0]         VOLT_CUTOFF, CURR_CUTOFF;
  logic [1:0]         CURR_CONV_TIME;
  logic [15:0]        CURR_TIME_US;
  logic signed [8:0]  MAIN_GAIN, AUX_GAIN;
  logic signed [6:0]  MAIN_OFFSET, AUX_OFFSET;
  logic signed [10:0] CURR_GAIN;
  logic signed [4:0]  CURR_OFFSET;
  logic [47:0]        t;
  logic [7:0]         e;
  logic [31:0]        seed;
  int                 n_errors, tests_run, i, j, n;
  int                 dl_tab[4] = '{3, 40, 41, 63};

  acc_ctrl acc_ctrl_inst (
    .CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .OTP_TRIM(OTP_TRIM),
    .ROUND_DONE(ROUND_DONE), .MAIN_CONV_EN(MAIN_CONV_EN),
    .AUX_SETTLED(AUX_SETTLED), .VOLT_CUTOFF(VOLT_CUTOFF),
    .VOLT_FILT_EN(VOLT_FILT_EN), .CURR_CUTOFF(CURR_CUTOFF),
    .CURR_FILT_EN(CURR_FILT_EN), .CURR_CONV_TIME(CURR_CONV_TIME),
    .CURR_TIME_US(CURR_TIME_US), .MAIN_GAIN(MAIN_GAIN),
    .MAIN_OFFSET(MAIN_OFFSET), .AUX_GAIN(AUX_GAIN),
    .AUX_OFFSET(AUX_OFFSET), .CURR_GAIN(CURR_GAIN),
    .CURR_OFFSET(CURR_OFFSET)
  );

  // 40 MHz clock
  initial
  begin
    CLK = 1'h0;
    forever #12.5 CLK = ~CLK;
  end

  // repeatable random source
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // expected single measurement time in microseconds
  function automatic logic [15:0] ct_us(input logic [1:0] c);
    case (c)
      2'h0: return 16'h0300;
      2'h1: return 16'h0600;
      2'h2: return 16'h0c00;
      default: return 16'h3000;
    endcase
  endfunction : ct_us

  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    tests_run++;
    if (g !== x)
    begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, x, g);
    end
  endtask : chk

  // one apb transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [11:0] idx,
                     input logic [7:0] wd);
    @(posedge CLK);
    PSEL    <= 1'h1;
    PENABLE <= 1'h0;
    PWRITE  <= w;
    PADDR   <= {idx, 2'h0};
    PWDATA  <= {24'h0, wd};
    @(posedge CLK);
    PENABLE <= 1'h1;
    do
      @(posedge CLK);
    while (PREADY !== 1'h1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL    <= 1'h0;
    PENABLE <= 1'h0;
    #1;
  endtask : apb

  task automatic rdchk(input string nm, input logic [11:0] idx,
                       input logic [7:0] x);
    apb(1'h0, idx, 8'h0);
    chk(nm, {24'h0, x}, rd);
    chk("rd err", 32'h0, {31'h0, err});
  endtask : rdchk

  // trims as signed numbers built from low and high parts
  task automatic chk_trim(input logic [47:0] v);
    chk("main gain", 32'($signed({v[39], v[47:40]})),
        32'(MAIN_GAIN));
    chk("main off", 32'($signed(v[38:32])), 32'(MAIN_OFFSET));
    chk("aux gain", 32'($signed({v[23], v[31:24]})), 32'(AUX_GAIN));
    chk("aux off", 32'($signed(v[22:16])), 32'(AUX_OFFSET));
    chk("cur gain", 32'($signed({v[7:5], v[15:8]})), 32'(CURR_GAIN));
    chk("cur off", 32'($signed(v[4:0])), 32'(CURR_OFFSET));
    for (int k = 0; k < 6; k++)
      rdchk("trim rd", 12'(`ACC_IDX_MGL + k), v[47-8*k -: 8]);
  endtask : chk_trim

  task automatic pulse(input int cnt);
    repeat (cnt)
    begin
      @(posedge CLK);
      ROUND_DONE <= 1'h1;
      @(posedge CLK);
      ROUND_DONE <= 1'h0;
    end
    repeat (3) @(posedge CLK);
    #1;
  endtask : pulse

  // start and measure the hold-off before the main converter runs
  task automatic start(input logic [1:0] m, input logic [5:0] dl);
    int c, lo, hi;
    lo = (dl == 0 || dl > 40) ? 0 : (int'(dl) - 1) * 200;
    hi = (dl == 0 || dl > 40) ? 2 : int'(dl) * 200 + 2;
    apb(1'h1, `ACC_IDX_DLY, {2'h0, dl});
    apb(1'h1, `ACC_IDX_RUN, {5'h0, 1'h1, m});
    c = 0;
    while (MAIN_CONV_EN !== 1'h1 && c < 9000)
    begin
      @(posedge CLK);
      #1;
      c++;
    end
    chk("delay", 32'h1, {31'h0, c >= lo && c <= hi});
    rdchk("start rd", `ACC_IDX_RUN, {6'h0, m});
  endtask : start

  task automatic stop(input logic [1:0] m);
    apb(1'h1, `ACC_IDX_RUN, {5'h0, 1'h1, m});
    repeat (3) @(posedge CLK);
    #1;
    chk("stopped", 32'h0, {31'h0, MAIN_CONV_EN});
  endtask : stop

  task automatic tally_and_finish();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  // hang guard
  initial
  begin
    repeat (80000) @(posedge CLK);
    n_errors++;
    tally_and_finish();
  end

  // main sequence
  initial
  begin
    seed = 32'h670a6d9a;
    {PSEL, PENABLE, PWRITE, ROUND_DONE, RESET_N} = 5'h0;
    PADDR = 14'h0;
    PWDATA = 32'h0;
    OTP_TRIM = {xs(), xs()};
    repeat (2) @(posedge CLK);
    RESET_N <= 1'h1;
    repeat (2) @(posedge CLK);
    chk_trim(OTP_TRIM[63:16]);
    rdchk("filt rst", `ACC_IDX_FILT, 8'h0);
    rdchk("run rst", `ACC_IDX_RUN, 8'h0);
    apb(1'h0, 12'h100, 8'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    chk("unmapped rd", 32'h0, rd);
    for (i = 0; i < 8; i++)
    begin
      d = xs();
      apb(1'h1, `ACC_IDX_FILT, d[7:0]);
      chk("volt cut", 32'(d[2:0]), 32'(VOLT_CUTOFF));
      chk("curr cut", 32'(d[5:3]), 32'(CURR_CUTOFF));
      rdchk("filt rd", `ACC_IDX_FILT, d[7:0]);
      e = {d[15], i[1:0], d[12:11], 3'h0};
      apb(1'h1, `ACC_IDX_RUN, e);
      chk("volt en", 32'(e[3]), 32'(VOLT_FILT_EN));
      chk("curr en", 32'(e[4]), 32'(CURR_FILT_EN));
      chk("time code", 32'(e[6:5]), 32'(CURR_CONV_TIME));
      chk("time us", 32'(ct_us(e[6:5])), 32'(CURR_TIME_US));
      rdchk("run rd", `ACC_IDX_RUN, e & 8'h7b);
      t = {xs(), xs()};
      for (j = 0; j < 6; j++)
        apb(1'h1, 12'(`ACC_IDX_MGL + j), t[47-8*j -: 8]);
      chk_trim(t);
    end
    // single run ends after the eighth round
    start(2'h1, 6'h0);
    pulse(7);
    chk("single 7", 32'h1, {31'h0, MAIN_CONV_EN});
    rdchk("status", `ACC_IDX_STAT, 8'h0f);
    pulse(1);
    chk("single 8", 32'h0, {31'h0, MAIN_CONV_EN});
    // continuous run ignores mode edits until the next start
    start(2'h2, 6'h1);
    pulse(10);
    apb(1'h1, `ACC_IDX_RUN, 8'h01);
    pulse(9);
    chk("cont", 32'h1, {31'h0, MAIN_CONV_EN});
    stop(2'h3);
    for (i = 0; i < 4; i++)
    begin
      start(2'h2, 6'(dl_tab[i]));
      stop(2'h0);
    end
    // settle code 10 waits 1.3 ms
    apb(1'h1, `ACC_IDX_FILT, 8'h80);
    start(2'h2, 6'h0);
    n = 0;
    while (AUX_SETTLED !== 1'h1 && n < 56000)
    begin
      @(posedge CLK);
      #1;
      n++;
    end
    chk("settle", 32'h1, {31'h0, n >= 51000 && n <= 53000});
    // reserved settle code drops the settled flag at once
    apb(1'h1, `ACC_IDX_FILT, 8'hc0);
    chk("settle rsvd", 32'h0, {31'h0, AUX_SETTLED});
    stop(2'h0);
    // a second reset reloads the one-time trims over software values
    @(posedge CLK);
    RESET_N <= 1'h0;
    repeat (2) @(posedge CLK);
    RESET_N <= 1'h1;
    repeat (2) @(posedge CLK);
    #1;
    chk("rst run", 32'h0, {31'h0, MAIN_CONV_EN});
    chk_trim(OTP_TRIM[63:16]);
    rdchk("filt rst2", `ACC_IDX_FILT, 8'h0);
    tally_and_finish();
  end
endmodule : test_adc_config_control
